// file: hw/rtc_divider_chain.sv
// Real time clock: source select, prescalers, 16-bit stage and 32-bit timer block
`timescale 1ns/100ps
`include "rtc_consts.svh"

module rtc_divider_chain (
	input  wire logic                 core_clk_in,    // 200 MHz clock
	input  wire logic                 reset_in,       // Power reset, sync, active high
	input  wire logic                 int_tick_in,    // Internal source count pulse
	input  wire logic                 ext_clk_in,     // External clock pin, async
	input  wire rtc_pkg::rtc_cfg_type cfg_in,         // Configuration
	input  wire rtc_pkg::rtc_wr_type  wr_in,          // Count register writes
	input  wire logic [4:0]           irq_clr_in,     // Flag clear pulses
	output logic [15:0]               prescale_timer_out, // 16-bit stage value
	output logic [15:0]               rtc_count_high_out, // Upper half of block
	output logic [15:0]               rtc_count_low_out,  // Lower half of block
	output logic [4:0]                irq_flags_out,  // Sticky stage requests
	output logic                      irq_out         // Shared request
);

	localparam int          STAGE_LSB [4] = '{`RTC_S0_LSB, `RTC_S1_LSB,
		`RTC_S2_LSB, `RTC_S3_LSB};
	localparam logic [31:0] STAGE_MSK [4] = '{`RTC_S0_MASK, `RTC_S1_MASK,
		`RTC_S2_MASK, `RTC_S3_MASK};

	rtc_pkg::rtc_state_type state_reg;
	rtc_pkg::rtc_state_type state_next;
	logic                   src_tick;
	logic                   tick32;
	logic                   tick8;
	logic [4:0]             events;
	logic                   carry;
	logic [31:0]            field;
	logic [31:0]            field_new;
	logic [31:0]            cnt;

	// ==================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		carry = 1'b0;
		field = 32'h0000_0000;
		field_new = 32'h0000_0000;
		cnt = state_reg.rtc;
		events = 5'h00;
		// Pin passes two flops; the third only serves edge detection
		state_next.ext_s1 = ext_clk_in;
		state_next.ext_s2 = state_reg.ext_s1;
		state_next.ext_s3 = state_reg.ext_s2;
		src_tick = cfg_in.src_ext ? (state_reg.ext_s2 & ~state_reg.ext_s3)
			: int_tick_in;
		if (cfg_in.pre32_en) begin
			tick32 = src_tick && (state_reg.pre32 == `RTC_PRE32_LAST);
			if (src_tick) begin
				state_next.pre32 = state_reg.pre32 + 5'h01;
			end
		end else begin
			tick32 = src_tick;
		end
		if (cfg_in.pre8_en) begin
			tick8 = tick32 && (state_reg.pre8 == `RTC_PRE8_LAST);
			if (tick32) begin
				state_next.pre8 = state_reg.pre8 + 3'h1;
			end
		end else begin
			tick8 = tick32;
		end
		// A software write wins over counting in the same cycle
		if (wr_in.wr_ptimer) begin
			state_next.ptimer = wr_in.data;
		end else if (tick8) begin
			if (state_reg.ptimer == `RTC_PTIMER_FULL) begin
				state_next.ptimer = cfg_in.ptimer_reload;
				events[0] = 1'b1;
			end else begin
				state_next.ptimer = state_reg.ptimer + 16'h0001;
			end
		end
		carry = events[0];
		for (int i = 0; i < 4; i++) begin
			field = (state_reg.rtc >> STAGE_LSB[i]) & STAGE_MSK[i];
			if (carry) begin
				if (field == STAGE_MSK[i]) begin
					field_new = (cfg_in.rtc_reload >> STAGE_LSB[i]) & STAGE_MSK[i];
					events[i+1] = 1'b1;
				end else begin
					field_new = field + 32'h0000_0001;
				end
				cnt = (cnt & ~(STAGE_MSK[i] << STAGE_LSB[i]))
					| ((field_new & STAGE_MSK[i]) << STAGE_LSB[i]);
			end
			carry = events[i+1];
		end
		if (wr_in.wr_low) begin
			cnt[15:0] = wr_in.data;
			events[2:1] = 2'h0;
		end
		if (wr_in.wr_high) begin
			cnt[31:16] = wr_in.data;
			events[4:3] = 2'h0;
		end
		state_next.rtc = cnt;
		// Set wins over a clear arriving in the same cycle
		state_next.flags = (state_reg.flags & ~irq_clr_in) | events;
		state_next.irq = |(state_next.flags & cfg_in.irq_en);
	end

	// ==================================================
	// State register; no other reset source reaches it
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_reg <= '{ptimer: `RTC_RESET_PTIMER,
				rtc: `RTC_RESET_CNT,
				default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign prescale_timer_out = state_reg.ptimer;
	assign rtc_count_high_out = state_reg.rtc[31:16];
	assign rtc_count_low_out  = state_reg.rtc[15:0];
	assign irq_flags_out      = state_reg.flags;
	assign irq_out            = state_reg.irq;

	// ==================================================
	// Assertions: source and prescalers
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	a_src_select: assert property (
		!cfg_in.src_ext |-> src_tick == int_tick_in)
		else $error("Internal source not selected");
	a_ext_edge: assert property (
		cfg_in.src_ext && state_reg.ext_s2 && !state_reg.ext_s3 |-> src_tick)
		else $error("External rising edge gave no tick");
	a_pre32_gate: assert property (
		cfg_in.pre32_en && tick32 |-> state_reg.pre32 == `RTC_PRE32_LAST && src_tick)
		else $error("Divide by 32 ticked early");
	a_pre8_gate: assert property (
		cfg_in.pre8_en && tick8 |-> state_reg.pre8 == `RTC_PRE8_LAST && tick32)
		else $error("Divide by 8 ticked early");

	// ==================================================
	// Assertions: 16-bit stage
	a_ptimer_counts_up: assert property (
		tick8 && !wr_in.wr_ptimer && state_reg.ptimer != `RTC_PTIMER_FULL
		|=> state_reg.ptimer == $past(state_reg.ptimer) + 16'h0001)
		else $error("16-bit stage did not increment");
	a_ptimer_reload: assert property (
		tick8 && !wr_in.wr_ptimer && state_reg.ptimer == `RTC_PTIMER_FULL
		|=> state_reg.ptimer == $past(cfg_in.ptimer_reload) && state_reg.flags[0])
		else $error("16-bit stage did not reload on overflow");
	a_ptimer_hold: assert property (
		!tick8 && !wr_in.wr_ptimer |=> $stable(state_reg.ptimer))
		else $error("16-bit stage moved without a tick");
	a_ptimer_write: assert property (
		wr_in.wr_ptimer |=> state_reg.ptimer == $past(wr_in.data))
		else $error("16-bit stage write lost");

	// ==================================================
	// Assertions: timer block
	a_block_hold: assert property (
		!events[0] && !wr_in.wr_low && !wr_in.wr_high |=> $stable(state_reg.rtc))
		else $error("Timer block moved without a carry");
	a_low_counts_up: assert property (
		events[0] && !wr_in.wr_low && state_reg.rtc[9:0] != 10'h3FF
		|=> state_reg.rtc[9:0] == $past(state_reg.rtc[9:0]) + 10'h001)
		else $error("First sub-counter did not increment");
	a_low_write: assert property (
		wr_in.wr_low |=> state_reg.rtc[15:0] == $past(wr_in.data))
		else $error("Low half write lost");
	a_high_write: assert property (
		wr_in.wr_high |=> state_reg.rtc[31:16] == $past(wr_in.data))
		else $error("High half write lost");
	a_sub_reload: assert property (
		events[1] |=> state_reg.rtc[9:0] == $past(cfg_in.rtc_reload[9:0]))
		else $error("First sub-counter did not reload on overflow");

	// ==================================================
	// Assertions: requests
	// The shared request is registered, so it follows the enables one edge late
	a_irq_merge: assert property (
		state_reg.irq == |(state_reg.flags & $past(cfg_in.irq_en)))
		else $error("Shared request does not match enabled flags");
	a_flag_sticky: assert property (
		!$past(reset_in)
		|-> (($past(state_reg.flags) & ~$past(irq_clr_in)) & ~state_reg.flags) == 5'h00)
		else $error("Request flag dropped without a clear");
	a_event_sets_flag: assert property (
		events != 5'h00 |=> (state_reg.flags & $past(events)) == $past(events))
		else $error("Stage event did not set its flag");
	a_flag_clear: assert property (
		irq_clr_in != 5'h00 |=> (state_reg.flags & $past(irq_clr_in) & ~$past(events)) == 5'h00)
		else $error("Cleared flag stayed set");

	// ==================================================
	// Assertions: power reset
	// Own disable term, otherwise the default one would hide the reset itself
	a_power_reset: assert property (disable iff (1'b0)
		reset_in |=> state_reg.ptimer == `RTC_RESET_PTIMER
			&& state_reg.rtc == `RTC_RESET_CNT
			&& state_reg.flags == 5'h00 && !state_reg.irq)
		else $error("Power reset left state behind");

	// ==================================================
	// Covers
	c_ptimer_overflow: cover property (events[0]);
	c_block_wrap: cover property (events[4]);
	c_set_and_clear: cover property (events[0] && irq_clr_in[0]);
	c_ext_source: cover property (cfg_in.src_ext && src_tick);
	c_both_prescalers: cover property (cfg_in.pre32_en && cfg_in.pre8_en && tick8);

endmodule

// file: hw/rtc_consts.svh
// Constants for the real time clock divider chain
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ==================================================
// Prescalers
`define RTC_PRE32_LAST 5'h1F
`define RTC_PRE8_LAST  3'h7

// ==================================================
// Reloadable 16-bit stage
`define RTC_PTIMER_FULL 16'hFFFF

// ==================================================
// Sub-counter layout inside the 32-bit block, lsb first
`define RTC_S0_LSB     0
`define RTC_S1_LSB     10
`define RTC_S2_LSB     16
`define RTC_S3_LSB     22
`define RTC_S0_MASK    32'h0000_03FF
`define RTC_S1_MASK    32'h0000_003F
`define RTC_S2_MASK    32'h0000_003F
`define RTC_S3_MASK    32'h0000_03FF

// ==================================================
// Power reset defaults
`define RTC_RESET_PTIMER 16'h0000
`define RTC_RESET_CNT  32'h0000_0000

`endif

// file: hw/rtc_pkg.sv
// Types shared by the real time clock divider chain
package rtc_pkg;

	// ==================================================
	// Configuration held by the surrounding system
	typedef struct packed {
		logic        src_ext;     // 1: external pin clock, 0: internal tick
		logic        pre32_en;    // Divide by 32 stage active
		logic        pre8_en;     // Divide by 8 stage active
		logic [15:0] ptimer_reload; // Start value of the 16-bit stage
		logic [31:0] rtc_reload;  // Start values of the four sub-counters
		logic [4:0]  irq_en;      // Per stage request enable
	} rtc_cfg_type;

	// ==================================================
	// Count register write port
	typedef struct packed {
		logic        wr_ptimer;
		logic        wr_low;
		logic        wr_high;
		logic [15:0] data;
	} rtc_wr_type;

	// ==================================================
	// Complete block state
	typedef struct packed {
		logic        ext_s1;
		logic        ext_s2;
		logic        ext_s3;
		logic [4:0]  pre32;
		logic [2:0]  pre8;
		logic [15:0] ptimer;
		logic [31:0] rtc;
		logic [4:0]  flags;
		logic        irq;
	} rtc_state_type;

endpackage

// file: dv/test_rtc_divider_chain.sv
// Self-checking testbench for the real time clock divider chain
`timescale 1ns/100ps

module test_rtc_divider_chain;

	logic                 core_clk_in;
	logic                 reset_in;
	logic                 int_tick_in;
	logic                 ext_clk_in;
	rtc_pkg::rtc_cfg_type cfg_in;
	rtc_pkg::rtc_wr_type  wr_in;
	logic [4:0]           irq_clr_in;
	logic [15:0]          prescale_timer_out;
	logic [15:0]          rtc_count_high_out;
	logic [15:0]          rtc_count_low_out;
	logic [4:0]           irq_flags_out;
	logic                 irq_out;
	int                   miscompares;
	int                   cmp_count;
	int                   cycle_count;

	rtc_divider_chain i_dut (
		.core_clk_in        (core_clk_in),
		.reset_in           (reset_in),
		.int_tick_in        (int_tick_in),
		.ext_clk_in         (ext_clk_in),
		.cfg_in             (cfg_in),
		.wr_in              (wr_in),
		.irq_clr_in         (irq_clr_in),
		.prescale_timer_out (prescale_timer_out),
		.rtc_count_high_out (rtc_count_high_out),
		.rtc_count_low_out  (rtc_count_low_out),
		.irq_flags_out      (irq_flags_out),
		.irq_out            (irq_out)
	);

	// ==================================================
	// Clock and hang guard
	always #2.5 core_clk_in = ~core_clk_in;

	always @(posedge core_clk_in) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == 5000) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end

	// ==================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_all(input logic [15:0] pt, input logic [15:0] hi, input logic [15:0] lo,
			input logic [4:0] flags, input logic irq);
		#1;
		check("prescale_timer", {16'h0000, pt}, {16'h0000, prescale_timer_out});
		check("rtc_count_high", {16'h0000, hi}, {16'h0000, rtc_count_high_out});
		check("rtc_count_low", {16'h0000, lo}, {16'h0000, rtc_count_low_out});
		check("irq_flags", {27'h000_0000, flags}, {27'h000_0000, irq_flags_out});
		check("irq", {31'h0000_0000, irq}, {31'h0000_0000, irq_out});
		// Return on an edge so that the next stimulus lands on one
		@(posedge core_clk_in);
	endtask

	// One source tick every other cycle; outputs settle after the sampling edge
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk_in) int_tick_in <= 1'b1;
			@(posedge core_clk_in) int_tick_in <= 1'b0;
		end
	endtask

	task automatic write(input logic [2:0] sel, input logic [15:0] data);
		@(posedge core_clk_in) wr_in <= {sel, data};
		@(posedge core_clk_in) wr_in <= '0;
	endtask

	task automatic clear_flags();
		@(posedge core_clk_in) irq_clr_in <= 5'h1F;
		@(posedge core_clk_in) irq_clr_in <= 5'h00;
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==================================================
	// Scenarios
	task automatic walk_one_tick();
		cfg_in.ptimer_reload <= 16'h1234;
		write(3'b100, 16'hFFFF);
		tick(1);
		check_all(16'h1234, 16'h0000, 16'h0001, 5'h01, 1'b1);
		tick(1);
		check_all(16'h1235, 16'h0000, 16'h0001, 5'h01, 1'b1);
		clear_flags();
		check_all(16'h1235, 16'h0000, 16'h0001, 5'h00, 1'b0);
	endtask

	task automatic prescalers();
		write(3'b100, 16'h0000);
		cfg_in.pre32_en <= 1'b1;
		tick(31);
		check_all(16'h0000, 16'h0000, 16'h0001, 5'h00, 1'b0);
		tick(1);
		check_all(16'h0001, 16'h0000, 16'h0001, 5'h00, 1'b0);
		cfg_in.pre8_en <= 1'b1;
		tick(255);
		check_all(16'h0001, 16'h0000, 16'h0001, 5'h00, 1'b0);
		tick(1);
		check_all(16'h0002, 16'h0000, 16'h0001, 5'h00, 1'b0);
		cfg_in.pre32_en <= 1'b0;
		cfg_in.pre8_en  <= 1'b0;
	endtask

	task automatic external_source();
		cfg_in.src_ext <= 1'b1;
		tick(1);
		repeat (3) begin
			@(posedge core_clk_in) ext_clk_in <= 1'b1;
			repeat (3) @(posedge core_clk_in);
			ext_clk_in <= 1'b0;
			repeat (3) @(posedge core_clk_in);
		end
		repeat (5) @(posedge core_clk_in);
		check_all(16'h0005, 16'h0000, 16'h0001, 5'h00, 1'b0);
		cfg_in.src_ext <= 1'b0;
	endtask

	// Overflow event and clear of the same flag in one cycle: the set must win
	task automatic set_beats_clear();
		write(3'h4, 16'hFFFF);
		@(posedge core_clk_in) begin
			int_tick_in <= 1'b1;
			irq_clr_in  <= 5'h1F;
		end
		@(posedge core_clk_in) begin
			int_tick_in <= 1'b0;
			irq_clr_in  <= 5'h00;
		end
		check_all(16'h1234, 16'h0000, 16'h0002, 5'h01, 1'b1);
		clear_flags();
		check_all(16'h1234, 16'h0000, 16'h0002, 5'h00, 1'b0);
	endtask

	// Power reset in mid-run returns every stage and flag to its default
	task automatic power_reset();
		@(posedge core_clk_in) reset_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		reset_in <= 1'b0;
		check_all(16'h0000, 16'h0000, 16'h0000, 5'h00, 1'b0);
	endtask

	// Every stage at all ones: one tick ripples through the whole chain
	task automatic full_ripple();
		cfg_in.rtc_reload <= 32'h0043_0805;
		cfg_in.irq_en     <= 5'h10;
		write(3'b100, 16'hFFFF);
		write(3'b010, 16'hFFFF);
		write(3'b001, 16'hFFFF);
		check_all(16'hFFFF, 16'hFFFF, 16'hFFFF, 5'h00, 1'b0);
		tick(1);
		check_all(16'h1234, 16'h0043, 16'h0805, 5'h1F, 1'b1);
		@(posedge core_clk_in) cfg_in.irq_en <= 5'h00;
		repeat (2) @(posedge core_clk_in);
		check_all(16'h1234, 16'h0043, 16'h0805, 5'h1F, 1'b0);
	endtask

	// ==================================================
	// Main sequence
	initial begin
		core_clk_in = 1'b0;
		reset_in    = 1'b1;
		int_tick_in = 1'b0;
		ext_clk_in  = 1'b0;
		cfg_in      = '0;
		cfg_in.irq_en = 5'h01;
		wr_in       = '0;
		irq_clr_in  = 5'h00;
		miscompares = 0;
		cmp_count   = 0;
		cycle_count = 0;
		repeat (6) @(posedge core_clk_in);
		reset_in <= 1'b0;
		check_all(16'h0000, 16'h0000, 16'h0000, 5'h00, 1'b0);
		walk_one_tick();
		prescalers();
		external_source();
		set_beats_clear();
		full_ripple();
		power_reset();
		print_verdict();
	end

endmodule
